// File: serial_baud_gen_and_port_ctrl.sv
// Bit-rate generator and serial pin control of the serial communication unit.
// Assumes a register master on core_clk, and pins and subclock from outside
// the clock domain; the shift logic sits outside and uses the ticks.
`timescale 1ns/1ps
`default_nettype none

module serial_baud_gen_and_port_ctrl
   import baud_pkg::*;
(
   // Clock and reset.
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // Register port.
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic       [DATA_W-1:0] reg_rdata,
   // Subclock pin.
   input  wire logic              subclk_in,
   // Transmitter, receiver and general port side.
   input  wire logic              tx_serial_data,
   input  wire logic              general_port_out,
   input  wire logic              general_port_oe,
   output logic                   rx_data_to_receiver,
   output logic                   base_clk_tick,
   output logic                   bit_clk_tick,
   output logic                   b2b_inhibit,
   // Shared transmit pin and receive pin.
   output logic                   serial_tx_line_out,
   output logic                   serial_tx_line_oe,
   input  wire logic              serial_rx_line
);

   logic [7:0] bit_rate_divisor_reg;
   logic       sync_mode_reg;
   prescale_t  prescale_reg;
   logic       async_base_clock_select_reg;
   logic       tx_pin_function_select_reg;
   logic       tx_output_invert_reg;
   logic       rx_input_invert_reg;
   logic       sub_s1_reg;
   logic       sub_s2_reg;
   logic       sub_s3_reg;
   logic       rx_s1_reg;
   logic       rx_s2_reg;
   logic [3:0] ovs_cnt_reg;
   logic [3:0] ovs_cnt_next;
   logic       gen_tick;
   logic       bit_tick_next;
   logic [7:0] rdata_next;

   // Write decode and generator restart.
   logic wr_div;
   logic wr_mode;
   logic wr_ext;
   logic wr_pin;
   logic restart;
   logic sub_edge;
   logic [3:0] ovs_last;
   logic [7:0] pin_view;
   logic b2b_next;

   assign wr_div   = reg_wr && (reg_addr == DIV_OFS);
   assign wr_mode  = reg_wr && (reg_addr == MODE_OFS);
   assign wr_ext   = reg_wr && (reg_addr == EXT_OFS);
   assign wr_pin   = reg_wr && (reg_addr == PIN_OFS);
   // Any change of rate setting starts a fresh period instead of finishing a stale one.
   assign restart  = wr_div || wr_mode || wr_ext;
   // Only the second and third flops feed the edge detector.
   assign sub_edge = sub_s2_reg && !sub_s3_reg;

   // Fixed bits are constants in the read view, so writes never reach them.
   assign pin_view = PIN_FIXED | {3'h0, tx_pin_function_select_reg, 2'h0,
                                  tx_output_invert_reg, rx_input_invert_reg};

   // Base ticks per bit: 2 in synchronous mode, else 16 or 8.
   assign ovs_last = sync_mode_reg ? OVS_SYNC_LAST :
                     async_base_clock_select_reg ? OVS_X8_LAST : OVS_X16_LAST;
   assign ovs_cnt_next  = restart ? 4'h0 :
                          !gen_tick ? ovs_cnt_reg :
                          (ovs_cnt_reg == ovs_last) ? 4'h0 : ovs_cnt_reg + 4'h1;
   assign bit_tick_next = gen_tick && !restart && (ovs_cnt_reg == ovs_last);

   // The fastest synchronous setting leaves the transmitter no time to reload.
   assign b2b_next = sync_mode_reg && (prescale_reg == PRE_SYS)
                     && (bit_rate_divisor_reg == 8'h00);

   // Read decode; unmapped addresses read as zero.
   always_comb begin
      if (reg_addr == DIV_OFS) begin
         rdata_next = bit_rate_divisor_reg;
      end else if (reg_addr == MODE_OFS) begin
         rdata_next = {sync_mode_reg, 5'h00, prescale_reg};
      end else if (reg_addr == EXT_OFS) begin
         rdata_next = {4'h0, async_base_clock_select_reg, 3'h0};
      end else if (reg_addr == PIN_OFS) begin
         rdata_next = pin_view;
      end else if (reg_addr == STAT_OFS) begin
         rdata_next = {b2b_inhibit, 3'h0, ovs_cnt_reg};
      end else begin
         rdata_next = ZERO_BYTE;
      end
   end

   // Generator prescaler and divisor counter.
   rate_gen u_rate_gen (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .prescale_sel (prescale_reg),
      .divisor      (bit_rate_divisor_reg),
      .restart      (restart),
      .sub_edge     (sub_edge),
      .gen_tick     (gen_tick)
   );

   // Rate registers.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bit_rate_divisor_reg        <= DIV_RST;
         sync_mode_reg               <= MODE_RST[MODE_SYNC_BIT];
         prescale_reg                <= PRE_SYS;
         async_base_clock_select_reg <= BIT_RST;
      end else begin
         if (wr_div) begin
            bit_rate_divisor_reg <= reg_wdata;
         end
         if (wr_mode) begin
            sync_mode_reg <= reg_wdata[MODE_SYNC_BIT];
            prescale_reg  <= prescale_t'(reg_wdata[MODE_SEL_HI:MODE_SEL_LO]);
         end
         if (wr_ext) begin
            async_base_clock_select_reg <= reg_wdata[EXT_ASYNC_BASE_CLOCK_SELECT_BIT];
         end
      end
   end

   // Pin control register; only the three writable bits are stored.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tx_pin_function_select_reg <= BIT_RST;
         tx_output_invert_reg       <= BIT_RST;
         rx_input_invert_reg        <= BIT_RST;
      end else if (wr_pin) begin
         tx_pin_function_select_reg <= reg_wdata[PIN_FN_BIT];
         tx_output_invert_reg       <= reg_wdata[PIN_TXINV_BIT];
         rx_input_invert_reg        <= reg_wdata[PIN_RXINV_BIT];
      end
   end

   // Two-flop synchronisers for the subclock and receive pins.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sub_s1_reg <= 1'b0;
         sub_s2_reg <= 1'b0;
         sub_s3_reg <= 1'b0;
         rx_s1_reg  <= 1'b1;
         rx_s2_reg  <= 1'b1;
      end else begin
         sub_s1_reg <= subclk_in;
         sub_s2_reg <= sub_s1_reg;
         sub_s3_reg <= sub_s2_reg;
         rx_s1_reg  <= serial_rx_line;
         rx_s2_reg  <= rx_s1_reg;
      end
   end

   // Ticks, read data and the inhibit flag.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ovs_cnt_reg   <= 4'h0;
         base_clk_tick <= 1'b0;
         bit_clk_tick  <= 1'b0;
         b2b_inhibit   <= 1'b0;
         reg_rdata     <= ZERO_BYTE;
      end else begin
         ovs_cnt_reg   <= ovs_cnt_next;
         base_clk_tick <= gen_tick && !restart;
         bit_clk_tick  <= bit_tick_next;
         b2b_inhibit   <= b2b_next;
         reg_rdata     <= reg_rd ? rdata_next : ZERO_BYTE;
      end
   end

   // Pin drive; inversion follows the register at once, so a write mid-frame can glitch.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         serial_tx_line_out  <= 1'b0;
         serial_tx_line_oe   <= 1'b0;
         rx_data_to_receiver <= 1'b1;
      end else begin
         serial_tx_line_out  <= tx_pin_function_select_reg ?
                                (tx_serial_data ^ tx_output_invert_reg) :
                                general_port_out;
         serial_tx_line_oe   <= tx_pin_function_select_reg || general_port_oe;
         rx_data_to_receiver <= rx_s2_reg ^ rx_input_invert_reg;
      end
   end

   // Helper counters for the checks: core cycles between base ticks, base ticks per bit.
   logic [15:0] gap_cnt_reg;
   logic        gap_valid_reg;
   logic [3:0]  bcnt_reg;
   logic        bit_valid_reg;

   always_ff @(posedge core_clk) begin
      if (!nrst || restart) begin
         gap_cnt_reg   <= 16'h0000;
         gap_valid_reg <= 1'b0;
         bcnt_reg      <= 4'h0;
         bit_valid_reg <= 1'b0;
      end else begin
         gap_cnt_reg   <= base_clk_tick ? 16'h0000 : gap_cnt_reg + 16'h0001;
         gap_valid_reg <= gap_valid_reg || base_clk_tick;
         bcnt_reg      <= bit_clk_tick ? 4'h0 : bcnt_reg + {3'h0, base_clk_tick};
         bit_valid_reg <= bit_valid_reg || bit_clk_tick;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_gen_sys;
      base_clk_tick && gap_valid_reg && (prescale_reg == PRE_SYS) && !restart
         |-> gap_cnt_reg == {7'h00, gen_reload(bit_rate_divisor_reg)};
   endproperty
   a_gen_sys: assert property (p_gen_sys) else $error("core clock base period wrong");

   property p_gen_div16;
      base_clk_tick && gap_valid_reg && (prescale_reg == PRE_DIV16)
         |-> gap_cnt_reg == {3'h0, bit_rate_divisor_reg, 5'h1F};
   endproperty
   a_gen_div16: assert property (p_gen_div16) else $error("core/16 base period wrong");

   property p_gen_div64;
      base_clk_tick && gap_valid_reg && (prescale_reg == PRE_DIV64)
         |-> gap_cnt_reg == {1'h0, bit_rate_divisor_reg, 7'h7F};
   endproperty
   a_gen_div64: assert property (p_gen_div64) else $error("core/64 base period wrong");

   property p_sync_bit;
      bit_clk_tick && bit_valid_reg && sync_mode_reg |-> bcnt_reg == OVS_SYNC_LAST;
   endproperty
   a_sync_bit: assert property (p_sync_bit) else $error("sync bit not two base ticks");

   property p_async_bit;
      bit_clk_tick && bit_valid_reg && !sync_mode_reg
         |-> bcnt_reg == (async_base_clock_select_reg ? OVS_X8_LAST : OVS_X16_LAST);
   endproperty
   a_async_bit: assert property (p_async_bit) else $error("async oversample wrong");

   // A rate write inside the 32-cycle window starts a new period, so it abandons the check.
   property p_max_rate;
      disable iff (!nrst || restart)
      bit_clk_tick && bit_valid_reg && !sync_mode_reg && !async_base_clock_select_reg
         && (prescale_reg == PRE_SYS) && (bit_rate_divisor_reg == 8'h00)
         |=> !bit_clk_tick [*8] ##1 !bit_clk_tick [*8] ##1 !bit_clk_tick [*8]
             ##1 !bit_clk_tick [*7] ##1 bit_clk_tick;
   endproperty
   a_max_rate: assert property (p_max_rate) else $error("max async rate not core/32");

   // The status read shows the flag as it stood in the cycle of the read strobe.
   property p_b2b;
      ##1 (b2b_inhibit == $past(b2b_next)) && (reg_rdata[STAT_B2B_BIT] == $past(b2b_inhibit)
         || !$past(reg_rd) || $past(reg_addr) != STAT_OFS);
   endproperty
   a_b2b: assert property (p_b2b) else $error("inhibit flag wrong");

   property p_pin_fixed;
      reg_rd && (reg_addr == PIN_OFS)
         |=> (reg_rdata[7:6] == 2'h3) && !reg_rdata[5] && (reg_rdata[3:2] == 2'h0);
   endproperty
   a_pin_fixed: assert property (p_pin_fixed) else $error("fixed pin bits wrong");

   property p_pin_readback;
      wr_pin ##1 (reg_rd && (reg_addr == PIN_OFS))
         |=> reg_rdata == (PIN_FIXED | ($past(reg_wdata, 2) & 8'h13));
   endproperty
   a_pin_readback: assert property (p_pin_readback) else $error("pin readback wrong");

   property p_tx_drive;
      tx_pin_function_select_reg |=> serial_tx_line_oe
         && (serial_tx_line_out == ($past(tx_serial_data) ^ $past(tx_output_invert_reg)));
   endproperty
   a_tx_drive: assert property (p_tx_drive) else $error("serial pin drive wrong");

   property p_gpio_drive;
      !tx_pin_function_select_reg |=> (serial_tx_line_out == $past(general_port_out))
         && (serial_tx_line_oe == $past(general_port_oe));
   endproperty
   a_gpio_drive: assert property (p_gpio_drive) else $error("port pin drive wrong");

   property p_rx_inv;
      ##3 rx_data_to_receiver == ($past(serial_rx_line, 3) ^ $past(rx_input_invert_reg));
   endproperty
   a_rx_inv: assert property (p_rx_inv) else $error("receive inversion wrong");

   property p_inv_now;
      wr_pin && reg_wdata[PIN_FN_BIT]
         |-> ##2 serial_tx_line_out == ($past(tx_serial_data) ^ $past(reg_wdata[1], 2));
   endproperty
   a_inv_now: assert property (p_inv_now) else $error("inversion not immediate");

   property p_restart;
      wr_div |=> !base_clk_tick ##1 !base_clk_tick;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after divisor write");

   // Every bit boundary must fall on a base tick, or the shift logic would lose phase.
   property p_tick_pair;
      bit_clk_tick |-> base_clk_tick;
   endproperty
   a_tick_pair: assert property (p_tick_pair) else $error("bit tick without base tick");

   // Read data stand for one cycle only, so an idle bus must show zero.
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == ZERO_BYTE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

   c_sync_bit: cover property (bit_clk_tick && sync_mode_reg);
   c_x8_bit: cover property (bit_clk_tick && !sync_mode_reg && async_base_clock_select_reg);
   c_sub_tick: cover property (base_clk_tick && (prescale_reg == PRE_SUB));
   c_b2b: cover property (b2b_inhibit && bit_clk_tick);
   c_x16_bit: cover property (bit_clk_tick && !sync_mode_reg && !async_base_clock_select_reg);

endmodule : serial_baud_gen_and_port_ctrl

`default_nettype wire

// File: baud_pkg.sv
// Constants shared by the bit-rate generator and the pin-control block.
// Assumes a single 200 MHz core clock and an 8-bit register port.
package baud_pkg;

   // Register port geometry.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets on the plain register port.
   localparam logic [3:0] DIV_OFS  = 4'h0;
   localparam logic [3:0] MODE_OFS = 4'h1;
   localparam logic [3:0] EXT_OFS  = 4'h2;
   localparam logic [3:0] PIN_OFS  = 4'h3;
   localparam logic [3:0] STAT_OFS = 4'h4;

   // Field positions.
   localparam int MODE_SYNC_BIT = 7;
   localparam int MODE_SEL_HI   = 1;
   localparam int MODE_SEL_LO   = 0;
   localparam int EXT_ASYNC_BASE_CLOCK_SELECT_BIT  = 3;
   localparam int PIN_FN_BIT    = 4;
   localparam int PIN_TXINV_BIT = 1;
   localparam int PIN_RXINV_BIT = 0;
   localparam int STAT_B2B_BIT  = 7;

   // Values after reset.
   localparam logic [7:0] DIV_RST   = 8'hFF;
   localparam logic [7:0] MODE_RST  = 8'h00;
   localparam logic       BIT_RST   = 1'h0;
   localparam logic [7:0] PIN_FIXED = 8'hC0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Generator input clock selection.
   typedef enum logic [1:0] {
      PRE_SYS   = 2'h0,
      PRE_SUB   = 2'h1,
      PRE_DIV16 = 2'h2,
      PRE_DIV64 = 2'h3
   } prescale_t;

   // Cycle counts of the prescaler and of the per-bit oversampling.
   localparam logic [3:0] PRE16_LAST    = 4'hF;
   localparam logic [5:0] PRE64_LAST    = 6'h3F;
   localparam logic [3:0] OVS_SYNC_LAST = 4'h1;
   localparam logic [3:0] OVS_X16_LAST  = 4'hF;
   localparam logic [3:0] OVS_X8_LAST   = 4'h7;

   // Generator reload: one tick every 2 x (divisor + 1) input clocks.
   function automatic logic [8:0] gen_reload(input logic [7:0] div);
      gen_reload = {div, 1'b1};
   endfunction : gen_reload

endpackage : baud_pkg

// File: rate_gen.sv
// Prescaler and reloading divisor counter of the bit-rate generator.
// Assumes restart and sub_edge are one-cycle pulses on core_clk.
`timescale 1ns/1ps
`default_nettype none

module rate_gen
   import baud_pkg::*;
(
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Control from the register file.
   input  wire prescale_t  prescale_sel,
   input  wire logic [7:0] divisor,
   input  wire logic       restart,
   input  wire logic       sub_edge,
   // One-cycle tick at the base clock rate.
   output logic            gen_tick
);

   logic [5:0] pre_cnt_reg;
   logic [5:0] pre_cnt_next;
   logic [8:0] div_cnt_reg;
   logic [8:0] div_cnt_next;
   logic       pre_en;
   logic       expire;
   logic       tick_next;

   // Input clock enable per prescale code; the subclock is only as fast as its edges.
   assign pre_en = (prescale_sel == PRE_SYS)   ? 1'b1 :
                   (prescale_sel == PRE_SUB)   ? sub_edge :
                   (prescale_sel == PRE_DIV16) ? (pre_cnt_reg[3:0] == PRE16_LAST) :
                                                 (pre_cnt_reg == PRE64_LAST);
   assign expire       = pre_en && (div_cnt_reg == 9'h000);
   assign pre_cnt_next = restart ? 6'h00 : pre_cnt_reg + 6'h01;
   // Twice the divisor plus one (gen_reload) used as the count, reloaded on every expiry.
   assign div_cnt_next = (restart || expire) ? gen_reload(divisor) :
                         pre_en ? div_cnt_reg - 9'h001 : div_cnt_reg;
   assign tick_next    = expire && !restart;

   // A restart realigns the prescaler too, so the first period is whole.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pre_cnt_reg <= 6'h00;
         div_cnt_reg <= 9'h1FF;
         gen_tick    <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         div_cnt_reg <= div_cnt_next;
         gen_tick    <= tick_next;
      end
   end

endmodule : rate_gen

`default_nettype wire

// File: remote_serial_dev.sv
// Model of the remote serial device that faces the transmit and receive pins.
// Assumes the bench hands it the level to send and samples what it sees.
`timescale 1ns/1ps
`default_nettype none

module remote_serial_dev (
   // Clock.
   input  wire logic core_clk,
   // Shared transmit pin as the block drives it.
   input  wire logic line_out,
   input  wire logic line_oe,
   // Level to send, the receive line, and the transmit level seen.
   input  wire logic send_bit,
   output logic      serial_rx_line,
   output logic      tx_seen
);
   logic last_reg;

   // The pin has no pull, so a released pin shows the inverse of its last level.
   assign tx_seen = line_oe ? line_out : ~last_reg;

   // The remote side always drives its line; it changes only on the core clock here.
   always_ff @(posedge core_clk) begin
      if (line_oe) begin
         last_reg <= line_out;
      end
      serial_rx_line <= send_bit;
   end
endmodule : remote_serial_dev
`default_nettype wire

// File: serial_baud_gen_and_port_ctrl_tb.sv
// Self-checking bench for the bit-rate generator and the pin control.
// Assumes the baud package, the design top and the remote device model.
`timescale 1ns/1ps
`default_nettype none

module serial_baud_gen_and_port_ctrl_tb;
   import baud_pkg::*;
   // Core cycles per base tick for divisor 0; the subclock period is 8 cycles.
   localparam int PER[4] = '{2, 16, 32, 128};
   logic              core_clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic [DATA_W-1:0] reg_rdata;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic              subclk_in = 1'b0;
   logic [2:0]        sub_cnt = 3'h0;
   logic              tx_serial_data = 1'b0;
   logic              general_port_out = 1'b0;
   logic              general_port_oe = 1'b0;
   logic              send_bit = 1'b1;
   logic              rx_data_to_receiver, base_clk_tick, bit_clk_tick, b2b_inhibit;
   logic              serial_tx_line_out, serial_tx_line_oe, serial_rx_line, tx_seen;
   logic              rd_seen = 1'b0;
   logic [31:0]       v;
   integer            seed = 32'ha8aa72bb;
   int                n_fail = 0;
   int                comparisons = 0;
   int                base_cnt = 0;
   int                bit_cnt = 0;
   int                k, n;
   logic [7:0]        rq[$];
   int                tq[$];
   int                bq[$];

   always #2.5 core_clk = ~core_clk;

   // The subclock toggles every 4 core cycles, in step with the core clock.
   always @(posedge core_clk) begin
      sub_cnt <= sub_cnt + 3'h1;
      subclk_in <= sub_cnt[2];
      rd_seen <= reg_rd;
   end

   serial_baud_gen_and_port_ctrl serial_baud_gen_and_port_ctrl_i (
      .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .subclk_in(subclk_in),
      .tx_serial_data(tx_serial_data), .general_port_out(general_port_out),
      .general_port_oe(general_port_oe), .rx_data_to_receiver(rx_data_to_receiver),
      .base_clk_tick(base_clk_tick), .bit_clk_tick(bit_clk_tick), .b2b_inhibit(b2b_inhibit),
      .serial_tx_line_out(serial_tx_line_out), .serial_tx_line_oe(serial_tx_line_oe),
      .serial_rx_line(serial_rx_line));

   remote_serial_dev remote_serial_dev_i (
      .core_clk(core_clk), .line_out(serial_tx_line_out), .line_oe(serial_tx_line_oe),
      .send_bit(send_bit), .serial_rx_line(serial_rx_line), .tx_seen(tx_seen));

   task automatic chk_num(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("[ERR] %s expected %0h seen %0h", what, e, g);
         n_fail++;
      end
   endtask : chk_num

   task automatic chk_lvl(input string what, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         $display("[ERR] %s expected %b seen %b", what, e, g);
         n_fail++;
      end
   endtask : chk_lvl

   // Results are judged on the falling edge, after every clocked update has landed.
   always @(negedge core_clk) begin
      base_cnt = base_cnt + 1;
      bit_cnt = bit_cnt + 1;
      if (rd_seen === 1'b1 && rq.size() > 0) chk_num("reg_rdata", rq.pop_front(), reg_rdata);
      if (base_clk_tick === 1'b1) begin
         if (tq.size() > 0) chk_num("base_period", tq.pop_front(), base_cnt);
         base_cnt = 0;
      end
      if (bit_clk_tick === 1'b1) begin
         if (bq.size() > 0) chk_num("bit_period", bq.pop_front(), bit_cnt);
         bit_cnt = 0;
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // A write followed at once by a read, with no idle cycle between the strobes.
   task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      rq.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : wr_rd

   // Mode 0 waits for a bit tick, mode 1 for every pending note to be taken.
   task automatic wait_until(input int what);
      int i;
      i = 0;
      do begin
         @(negedge core_clk);
         i++;
      end while (i < 20000 && (what == 0 ? bit_clk_tick !== 1'b1
                                         : tq.size() + bq.size() + rq.size() > 0));
      if (i == 20000) begin
         n_fail++;
         final_report();
      end
   endtask : wait_until

   // The first period after a rate write is skipped, since it includes the restart lag.
   task automatic rate_case(input logic [7:0] mode, input logic [7:0] ext,
                            input logic [7:0] div, input int base, input int ratio);
      wr(EXT_OFS, ext);
      wr(MODE_OFS, mode);
      wr(DIV_OFS, div);
      wait_until(0);
      chk_lvl("b2b_inhibit", mode[7] && mode[1:0] == 2'h0 && div == 8'h00, b2b_inhibit);
      // Just after a bit boundary the oversample count is back at zero.
      rd(STAT_OFS, {mode[7] && mode[1:0] == 2'h0 && div == 8'h00, 7'h00});
      tq.push_back(base);
      tq.push_back(base);
      bq.push_back(base * ratio);
      wait_until(1);
   endtask : rate_case

   task automatic final_report();
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      // Reset values, then an unmapped place that reads zero.
      rd(DIV_OFS, DIV_RST);
      rd(MODE_OFS, MODE_RST);
      rd(EXT_OFS, ZERO_BYTE);
      rd(PIN_OFS, PIN_FIXED);
      rd(4'h7, ZERO_BYTE);
      // The fixed pin control bits ignore writes while the live bits follow them.
      wr_rd(PIN_OFS, 8'h3F, 8'hD3);
      // Every prescale code in synchronous mode; code 01 runs from the subclock.
      for (k = 0; k < 4; k++) begin
         n = $random(seed) & 15;
         rate_case({1'b1, 5'h00, k[1:0]}, 8'h00, n[7:0], PER[k] * (n + 1), 2);
      end
      rate_case(8'h00, 8'h00, 8'h00, 2, 16);
      rate_case(8'h00, 8'h08, 8'h00, 2, 8);
      rate_case(8'h80, 8'h00, 8'h00, 2, 2);
      rate_case(8'h00, 8'h08, 8'hFF, 512, 8);
      // Ticks are now slow, so a wait for a bit boundary would show on the pin.
      for (k = 0; k < 16; k++) begin
         @(posedge core_clk);
         v = $random(seed);
         tx_serial_data <= v[0];
         general_port_out <= v[1];
         general_port_oe <= v[2];
         send_bit <= v[3];
         // The lines are steady while pin control changes, so the glitch is harmless.
         wr(PIN_OFS, {3'h0, v[4], 2'h0, v[5], v[6]});
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk_lvl("tx_oe", v[4] ? 1'b1 : v[2], serial_tx_line_oe);
         chk_lvl("tx_out", v[4] ? v[0] ^ v[5] : v[1], serial_tx_line_out);
         if (v[4]) chk_lvl("tx_seen", v[0] ^ v[5], tx_seen);
         repeat (5) @(negedge core_clk);
         chk_lvl("rx_data", v[3] ^ v[6], rx_data_to_receiver);
      end
      // A second reset in mid-run returns pin control to its initial value.
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      rd(PIN_OFS, PIN_FIXED);
      rd(DIV_OFS, DIV_RST);
      wait_until(1);
      final_report();
   end
endmodule : serial_baud_gen_and_port_ctrl_tb
`default_nettype wire
